// ==== sync_timer_regs.svh ====
// Register offsets, field positions, reset values and mode codes of the synchronized timer pair.
`ifndef SYNC_TIMER_REGS_SVH
`define SYNC_TIMER_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (word addresses on the plain register port).
// ----------------------------------------------------------------------------
`define MASTER_CONTROL_REG_0_OFS 4'h0
`define MASTER_CONTROL_REG_1_OFS 4'h1
`define SLAVE_CONTROL_REG_0_OFS  4'h2
`define SLAVE_CONTROL_REG_1_OFS  4'h3
`define MASTER_COMPARE_0_OFS     4'h4
`define MASTER_COMPARE_1_OFS     4'h5
`define SLAVE_COMPARE_0_OFS      4'h6
`define SLAVE_COMPARE_1_OFS      4'h7
`define MASTER_COUNT_OFS         4'h8
`define SLAVE_COUNT_OFS          4'h9
`define STATUS_OFS               4'hA

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define RUN_BIT_POS      0
`define SYNC_BIT_POS     7
`define MODE_LSB         0
`define MODE_MSB         2

// ----------------------------------------------------------------------------
// Mode codes and reset values.
// ----------------------------------------------------------------------------
`define MODE_FREE_RUN    3'h5
`define MODE_PWM         3'h4
`define MODE_TRI_PWM     3'h7
`define CTRL_RESET       8'h00
`define COMPARE_RESET    16'h0000
`define COUNT_RESET      16'h0000

`endif

// ==== sync_timer_pkg.sv ====
// Types shared by the synchronized timer pair.
package sync_timer_pkg;
   typedef enum logic [1:0] {
      pair_free_run,
      pair_pwm,
      pair_tri_pwm,
      pair_other
   } pair_mode_t;
endpackage

// ==== master_slave_timer_sync.sv ====
// Master and slave 16-bit timer pair with synchronized (tuned) operation.
//
// Operation
// - With sync on, slave starts with master and counts on master's count clock.
// - With sync on, clearing the master counter clears the slave counter in the same cycle.
// - Master mode: 101 free-running, 100 PWM, 111 triangular PWM; governs the pair.
// - With sync on, master run bit set to 1 starts the whole pair; software sets it last.
// - PWM with sync: slave output 0 is PWM; master output 0 toggles.
// - Free-running: compare writes reach the active compare at once.
// - PWM modes: buffered compares transfer only on master count equal compare 0.
`timescale 1ns/100ps
`include "sync_timer_regs.svh"

module master_slave_timer_sync (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic        count_tick_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [15:0] rdata_out,
   output logic             master_a_output_0_out,
   output logic             master_a_output_1_out,
   output logic             slave_a_output_0_out,
   output logic             slave_a_output_1_out
);

   // -------------------------------------------------------------------------
   // Register state.
   // -------------------------------------------------------------------------
   logic [7:0]  master_control_reg_0;
   logic [7:0]  master_control_reg_1;
   logic [7:0]  slave_control_reg_0;
   logic [7:0]  slave_control_reg_1;
   logic [15:0] master_compare_buf [2];
   logic [15:0] slave_compare_buf  [2];
   logic [15:0] master_compare_act [2];
   logic [15:0] slave_compare_act  [2];
   logic [15:0] master_count;
   logic [15:0] slave_count;
   logic [3:0]  outs;
   logic [15:0] rdata;

   logic [7:0]  next_master_control_reg_0;
   logic [7:0]  next_master_control_reg_1;
   logic [7:0]  next_slave_control_reg_0;
   logic [7:0]  next_slave_control_reg_1;
   logic [15:0] next_master_compare_buf [2];
   logic [15:0] next_slave_compare_buf  [2];
   logic [15:0] next_master_compare_act [2];
   logic [15:0] next_slave_compare_act  [2];
   logic [15:0] next_master_count;
   logic [15:0] next_slave_count;
   logic [3:0]  next_outs;
   logic [15:0] next_rdata;

   logic                     master_run;
   logic                     slave_run;
   logic                     sync_on;
   logic [2:0]               master_mode_field;
   logic [2:0]               slave_mode_field;
   sync_timer_pkg::pair_mode_t pair_mode;
   logic                     master_clear;
   logic                     transfer;
   logic                     pwm_like;

   // Decode of control fields.
   assign master_run        = master_control_reg_0[`RUN_BIT_POS];
   assign slave_run         = slave_control_reg_0[`RUN_BIT_POS];
   assign sync_on           = slave_control_reg_1[`SYNC_BIT_POS];
   assign master_mode_field = master_control_reg_1[`MODE_MSB:`MODE_LSB];
   assign slave_mode_field  = slave_control_reg_1[`MODE_MSB:`MODE_LSB];

   // Master mode selects the behaviour of the synchronized pair.
   always_comb begin
      unique case (master_mode_field)
         `MODE_FREE_RUN: pair_mode = sync_timer_pkg::pair_free_run;
         `MODE_PWM:      pair_mode = sync_timer_pkg::pair_pwm;
         `MODE_TRI_PWM:  pair_mode = sync_timer_pkg::pair_tri_pwm;
         default:        pair_mode = sync_timer_pkg::pair_other;
      endcase
   end

   // The master clears on compare 0 in the PWM modes, and wraps in free-running.
   assign pwm_like     = (pair_mode == sync_timer_pkg::pair_pwm) ||
                         (pair_mode == sync_timer_pkg::pair_tri_pwm);
   assign master_clear = master_run && count_tick_in && pwm_like &&
                         (master_count == master_compare_act[0]);
   assign transfer     = master_run && count_tick_in &&
                         (master_count == master_compare_act[0]);

   // -------------------------------------------------------------------------
   // Next-state logic for registers, counters and outputs.
   // -------------------------------------------------------------------------
   always_comb begin
      next_master_control_reg_0 = master_control_reg_0;
      next_master_control_reg_1 = master_control_reg_1;
      next_slave_control_reg_0  = slave_control_reg_0;
      next_slave_control_reg_1  = slave_control_reg_1;
      next_master_compare_buf   = master_compare_buf;
      next_slave_compare_buf    = slave_compare_buf;
      next_master_compare_act   = master_compare_act;
      next_slave_compare_act    = slave_compare_act;
      next_master_count         = master_count;
      next_slave_count          = slave_count;
      next_outs                 = outs;
      next_rdata                = 16'h0000;

      // Compare transfer in the PWM modes happens before a same-cycle write lands.
      if (pwm_like && transfer) begin
         next_master_compare_act = master_compare_buf;
         next_slave_compare_act  = slave_compare_buf;
      end

      // Register writes from software.
      if (wr_in) begin
         unique case (addr_in)
            `MASTER_CONTROL_REG_0_OFS: next_master_control_reg_0 = wdata_in[7:0];
            `MASTER_CONTROL_REG_1_OFS: next_master_control_reg_1 = wdata_in[7:0];
            `SLAVE_CONTROL_REG_0_OFS:  next_slave_control_reg_0  = wdata_in[7:0];
            `SLAVE_CONTROL_REG_1_OFS:  next_slave_control_reg_1  = wdata_in[7:0];
            `MASTER_COMPARE_0_OFS:     next_master_compare_buf[0] = wdata_in;
            `MASTER_COMPARE_1_OFS:     next_master_compare_buf[1] = wdata_in;
            `SLAVE_COMPARE_0_OFS:      next_slave_compare_buf[0]  = wdata_in;
            `SLAVE_COMPARE_1_OFS:      next_slave_compare_buf[1]  = wdata_in;
            default: ;
         endcase
         // Free-running mode writes straight through to the active compare.
         if (!pwm_like) begin
            unique case (addr_in)
               `MASTER_COMPARE_0_OFS: next_master_compare_act[0] = wdata_in;
               `MASTER_COMPARE_1_OFS: next_master_compare_act[1] = wdata_in;
               `SLAVE_COMPARE_0_OFS:  next_slave_compare_act[0]  = wdata_in;
               `SLAVE_COMPARE_1_OFS:  next_slave_compare_act[1]  = wdata_in;
               default: ;
            endcase
         end
      end

      // Master counter and its outputs.
      if (!master_run) begin
         next_master_count = `COUNT_RESET;
         next_outs[1:0]    = 2'h0;
      end else if (count_tick_in) begin
         if (master_clear) begin
            next_master_count = `COUNT_RESET;
         end else begin
            next_master_count = master_count + 16'h0001;
         end
         // Output 0 of the master always toggles on its compare 0 match.
         if (master_count == master_compare_act[0]) begin
            next_outs[0] = ~outs[0];
         end
         if (pwm_like) begin
            if (master_clear) begin
               next_outs[1] = 1'b0;
            end else if (master_count == master_compare_act[1]) begin
               next_outs[1] = 1'b1;
            end
         end else if (master_count == master_compare_act[1]) begin
            next_outs[1] = ~outs[1];
         end
      end

      // Slave counter: in sync it follows the master run state and tick, not its own run bit.
      if (sync_on) begin
         if (!master_run) begin
            next_slave_count = `COUNT_RESET;
            next_outs[3:2]   = 2'h0;
         end else if (count_tick_in) begin
            if (master_clear) begin
               next_slave_count = `COUNT_RESET;
            end else begin
               next_slave_count = slave_count + 16'h0001;
            end
            // Both slave outputs go PWM in sync PWM; the period comes from the master.
            if (pwm_like) begin
               if (master_clear) begin
                  next_outs[3:2] = 2'h0;
               end else begin
                  if (slave_count == slave_compare_act[0]) next_outs[2] = 1'b1;
                  if (slave_count == slave_compare_act[1]) next_outs[3] = 1'b1;
               end
            end else begin
               if (slave_count == slave_compare_act[0]) next_outs[2] = ~outs[2];
               if (slave_count == slave_compare_act[1]) next_outs[3] = ~outs[3];
            end
         end
      end else if (!slave_run) begin
         next_slave_count = `COUNT_RESET;
         next_outs[3:2]   = 2'h0;
      end else if (count_tick_in) begin
         // Unsynchronized slave runs free on its own run bit; both outputs toggle.
         next_slave_count = slave_count + 16'h0001;
         if (slave_count == slave_compare_act[0]) next_outs[2] = ~outs[2];
         if (slave_count == slave_compare_act[1]) next_outs[3] = ~outs[3];
      end

      // Read data, valid in the cycle after the strobe.
      if (rd_in) begin
         unique case (addr_in)
            `MASTER_CONTROL_REG_0_OFS: next_rdata = {8'h00, master_control_reg_0};
            `MASTER_CONTROL_REG_1_OFS: next_rdata = {8'h00, master_control_reg_1};
            `SLAVE_CONTROL_REG_0_OFS:  next_rdata = {8'h00, slave_control_reg_0};
            `SLAVE_CONTROL_REG_1_OFS:  next_rdata = {8'h00, slave_control_reg_1};
            `MASTER_COMPARE_0_OFS:     next_rdata = master_compare_buf[0];
            `MASTER_COMPARE_1_OFS:     next_rdata = master_compare_buf[1];
            `SLAVE_COMPARE_0_OFS:      next_rdata = slave_compare_buf[0];
            `SLAVE_COMPARE_1_OFS:      next_rdata = slave_compare_buf[1];
            `MASTER_COUNT_OFS:         next_rdata = master_count;
            `SLAVE_COUNT_OFS:          next_rdata = slave_count;
            `STATUS_OFS:               next_rdata = {9'h000, slave_mode_field, outs};
            default:                   next_rdata = 16'h0000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // State registers.
   // -------------------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         master_control_reg_0 <= `CTRL_RESET;
         master_control_reg_1 <= `CTRL_RESET;
         slave_control_reg_0  <= `CTRL_RESET;
         slave_control_reg_1  <= `CTRL_RESET;
         master_compare_buf   <= '{`COMPARE_RESET, `COMPARE_RESET};
         slave_compare_buf    <= '{`COMPARE_RESET, `COMPARE_RESET};
         master_compare_act   <= '{`COMPARE_RESET, `COMPARE_RESET};
         slave_compare_act    <= '{`COMPARE_RESET, `COMPARE_RESET};
         master_count         <= `COUNT_RESET;
         slave_count          <= `COUNT_RESET;
         outs                 <= 4'h0;
         rdata                <= 16'h0000;
      end else begin
         master_control_reg_0 <= next_master_control_reg_0;
         master_control_reg_1 <= next_master_control_reg_1;
         slave_control_reg_0  <= next_slave_control_reg_0;
         slave_control_reg_1  <= next_slave_control_reg_1;
         master_compare_buf   <= next_master_compare_buf;
         slave_compare_buf    <= next_slave_compare_buf;
         master_compare_act   <= next_master_compare_act;
         slave_compare_act    <= next_slave_compare_act;
         master_count         <= next_master_count;
         slave_count          <= next_slave_count;
         outs                 <= next_outs;
         rdata                <= next_rdata;
      end
   end

   // Outputs come straight from flip-flops.
   assign rdata_out             = rdata;
   assign master_a_output_0_out = outs[0];
   assign master_a_output_1_out = outs[1];
   assign slave_a_output_0_out  = outs[2];
   assign slave_a_output_1_out  = outs[3];

endmodule

// ==== sync_timer_sva.sv ====
// Port-level assertions for the synchronized timer pair.
`timescale 1ns/100ps
`include "sync_timer_regs.svh"
module sync_timer_sva (
   input wire logic        mclk_in,
   input wire logic        reset_in,
   input wire logic        count_tick_in,
   input wire logic [3:0]  addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic        master_a_output_0_out,
   input wire logic        master_a_output_1_out,
   input wire logic        slave_a_output_0_out,
   input wire logic        slave_a_output_1_out
);
   logic [19:0] shadow;
   logic [19:0] next_shadow;
   logic [3:0]  pins;
   // Shadow of run bit, slave mode and master compare 0, taken from the writes only.
   always_comb begin
      next_shadow = shadow;
      if (wr_in && addr_in == `MASTER_CONTROL_REG_0_OFS) next_shadow[19] = wdata_in[0];
      if (wr_in && addr_in == `SLAVE_CONTROL_REG_1_OFS) next_shadow[18:16] = wdata_in[2:0];
      if (wr_in && addr_in == `MASTER_COMPARE_0_OFS) next_shadow[15:0] = wdata_in;
   end
   always_ff @(posedge mclk_in) shadow <= reset_in ? 20'h00000 : next_shadow;
   assign pins = {slave_a_output_1_out, slave_a_output_0_out, master_a_output_1_out,
                  master_a_output_0_out};
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   read_idle_zero_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
      else $error("read data not zero outside a read answer");
   unmapped_read_a: assert property ($past(rd_in && addr_in > `STATUS_OFS) |-> rdata_out == 0)
      else $error("unmapped read not zero");
   ctrl_upper_zero_a: assert property ($past(rd_in && addr_in < `MASTER_COMPARE_0_OFS)
      |-> rdata_out[15:8] == 8'h00) else $error("control read upper byte not zero");
   compare_readback_a: assert property ($past(rd_in && addr_in == `MASTER_COMPARE_0_OFS)
      |-> rdata_out == $past(shadow[15:0])) else $error("compare read differs from write");
   status_mirror_a: assert property ($past(rd_in && addr_in == `STATUS_OFS)
      |-> rdata_out[6:0] == {$past(shadow[18:16]), $past(pins)}) else $error("status mismatch");
   stop_pins_low_a: assert property (!shadow[19] && !$past(shadow[19]) |-> pins == 4'h0)
      else $error("outputs active while stopped");
   stop_count_zero_a: assert property ($past(rd_in && addr_in[3:1] == 3'h4 && !shadow[19])
      && !$past(shadow[19], 2) |-> rdata_out == 16'h0000) else $error("count moved while stopped");
   master_on_tick_a: assert property (shadow[19] && $past(shadow[19]) && $changed(pins[1:0])
      |-> $past(count_tick_in)) else $error("master output moved without a count step");
   slave_on_tick_a: assert property (shadow[19] && $past(shadow[19]) && $changed(pins[3:2])
      |-> $past(count_tick_in)) else $error("slave output moved without a count step");
   cover property (shadow[19] && rd_in && addr_in == `SLAVE_COUNT_OFS);
   cover property ($rose(slave_a_output_0_out));
   cover property (shadow[19] && $fell(master_a_output_1_out));
endmodule

// ==== tick_source.sv ====
// Count clock source standing in for the master channel's count clock.
`timescale 1ns/100ps
module tick_source (
   input  wire logic       mclk_in,
   input  wire logic       reset_in,
   input  wire logic       go_in,
   input  wire logic [7:0] num_in,
   input  wire logic [1:0] gap_in,
   output logic            tick_out,
   output logic            busy_out
);
   logic [7:0] left;
   logic [7:0] next_left;
   logic [1:0] idle;
   logic [1:0] next_idle;
   logic       next_tick;
   // One-cycle steps with an idle gap, so both a prompt and a slow count clock are seen.
   always_comb begin
      next_left = left;
      next_idle = (idle != 2'h0) ? idle - 2'h1 : idle;
      next_tick = 1'b0;
      if (go_in) begin
         next_left = num_in;
         next_idle = 2'h0;
      end else if (left != 8'h00 && idle == 2'h0) begin
         next_tick = 1'b1;
         next_left = left - 8'h01;
         next_idle = gap_in;
      end
   end
   always_ff @(posedge mclk_in) {left, idle, tick_out} <= reset_in ? 11'h000 : {next_left, next_idle, next_tick};
   assign busy_out = (left != 8'h00) || tick_out;
endmodule

// ==== master_slave_timer_sync_bench.sv ====
// Self-checking bench for the synchronized timer pair.
`timescale 1ns/100ps
`include "sync_timer_regs.svh"
module master_slave_timer_sync_bench;
   logic        mclk_in, reset_in, tick, go, busy, wr_in, rd_in, m0, m1, s0, s1;
   logic [3:0]  addr_in;
   logic [15:0] wdata_in, rdata_out, got, v, mc, act0, buf0;
   logic [2:0]  mmode;
   logic [7:0]  num;
   logic [1:0]  gap;
   int          miscompares, checked;
   master_slave_timer_sync uut (.mclk_in(mclk_in), .reset_in(reset_in), .count_tick_in(tick),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .master_a_output_0_out(m0), .master_a_output_1_out(m1), .slave_a_output_0_out(s0),
      .slave_a_output_1_out(s1));
   tick_source far (.mclk_in(mclk_in), .reset_in(reset_in), .go_in(go), .num_in(num),
      .gap_in(gap), .tick_out(tick), .busy_out(busy));
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // Bus write; the model tracks the mode and where compare 0 lands.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
      @(posedge mclk_in);
      wr_in <= 1'b0;
      if (a == `MASTER_CONTROL_REG_1_OFS) mmode = d[2:0];
      if (a == `MASTER_COMPARE_0_OFS) buf0 = d;
      if (a == `MASTER_COMPARE_0_OFS && mmode == `MODE_FREE_RUN) act0 = d;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_in);
      {rd_in, addr_in} <= {1'b1, a};
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 got = rdata_out;
   endtask
   task automatic cmp16(input logic [15:0] g, input logic [15:0] e, input string what);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, g, e);
      end
   endtask
   // All four outputs are compared, so the master's toggling output 0 is watched too.
   task automatic cmp_pins(input logic [3:0] e);
      checked++;
      if ({s1, s0, m1, m0} !== e) begin
         miscompares++;
         $display("[ERR] %0t pins %b want %b", $time, {s1, s0, m1, m0}, e);
      end
   endtask
   // Count steps from the far side, then advance the expected count the same way.
   task automatic ticks(input logic [7:0] n);
      @(posedge mclk_in);
      {num, gap, go} <= {n, 2'($urandom_range(3)), 1'b1};
      @(posedge mclk_in);
      go <= 1'b0;
      for (int i = 0; i < 2000 && (busy !== 1'b0 || i == 0); i++) @(posedge mclk_in);
      repeat (n) begin
         if (mmode != `MODE_FREE_RUN && mc == act0) {mc, act0} = {16'h0000, buf0};
         else mc = mc + 16'h0001;
      end
   endtask
   task automatic counts();
      rd(`MASTER_COUNT_OFS);
      cmp16(got, mc, "master count");
      rd(`SLAVE_COUNT_OFS);
      cmp16(got, mc, "slave count");
   endtask
   // Stop, program slave then compares then mode, start last; slave run bit stays 0.
   task automatic setup(input logic [2:0] mode, input logic [15:0] p);
      wr(`MASTER_CONTROL_REG_0_OFS, 16'h0000);
      mc = 16'h0000;
      wr(`SLAVE_CONTROL_REG_1_OFS, 16'h0085);
      wr(`SLAVE_COMPARE_0_OFS, 16'h0002);
      wr(`SLAVE_COMPARE_1_OFS, 16'h0003);
      wr(`MASTER_COMPARE_0_OFS, p);
      wr(`MASTER_COMPARE_1_OFS, 16'h0004);
      wr(`MASTER_CONTROL_REG_1_OFS, {13'h0000, mode});
      wr(`MASTER_CONTROL_REG_0_OFS, 16'h0001);
   endtask
   task automatic conclude();
      $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
   initial begin
      {reset_in, wr_in, rd_in, go, addr_in, wdata_in, num, gap} = {4'h8, 4'h0, 16'h0000, 10'h000};
      {miscompares, checked, mc, act0, buf0, mmode} = '0;
      void'($urandom(10910));
      repeat (3) @(posedge mclk_in);
      reset_in <= 1'b0;
      for (int a = 0; a < 16; a++) begin
         rd(4'(a));
         cmp16(got, 16'h0000, "reset value");
      end
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         v = 16'($urandom);
         wr(`SLAVE_COMPARE_1_OFS, v);
         rd(`SLAVE_COMPARE_1_OFS);
         cmp16(got, v, "compare readback");
         wr(4'hB + 4'(i % 5), v);
         rd(4'hB + 4'(i % 5));
         cmp16(got, 16'h0000, "unmapped place");
      end
      for (int k = 0; k < 3; k++) begin
         v = {13'h0000, 3'(9'({`MODE_TRI_PWM, `MODE_PWM, `MODE_FREE_RUN}) >> (3 * k))};
         wr(`MASTER_CONTROL_REG_1_OFS, v);
         rd(`MASTER_CONTROL_REG_1_OFS);
         cmp16(got, v, "master mode code");
      end
      $display("test register access done");
      setup(`MODE_FREE_RUN, 16'($urandom_range(5, 30)));
      ticks(8'($urandom_range(20, 60)));
      counts();
      $display("test free-running pair done");
      setup(`MODE_PWM, 16'h0009);
      ticks(8'h06);
      cmp_pins(4'b1110);
      ticks(8'h04);
      cmp_pins(4'b0001);
      rd(`STATUS_OFS);
      cmp16({13'h0000, got[6:4]}, 16'h0005, "slave mode in status");
      ticks(8'h04);
      wr(`MASTER_COMPARE_0_OFS, 16'h0002);
      ticks(8'($urandom_range(8, 16)));
      counts();
      $display("test pwm pair done");
      wr(`MASTER_CONTROL_REG_0_OFS, 16'h0000);
      ticks(8'h05);
      // A stopped pair ignores count steps, so the model's advance is undone here.
      mc = 16'h0000;
      counts();
      cmp_pins(4'b0000);
      $display("test stop done");
      conclude();
   end
endmodule
bind master_slave_timer_sync sync_timer_sva chk (.mclk_in(mclk_in), .reset_in(reset_in),
   .count_tick_in(count_tick_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .master_a_output_0_out(master_a_output_0_out),
   .master_a_output_1_out(master_a_output_1_out), .slave_a_output_0_out(slave_a_output_0_out),
   .slave_a_output_1_out(slave_a_output_1_out));
